//--- hdl/mvd_core.sv
// move-instruction datapath with an apb slave for execution and inspection
// assumes one core clock; writing INSTR executes one instruction in that cycle
//
// Notes on behaviour
// RULE1: indirect load reads memory at selected pointer's address into accumulator, updates zero
// RULE2: mode 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec
// RULE3: relative form addresses pointer plus signed offset -32..31, pointer unchanged
// RULE4: indirect window address has no storage; redirects to the pointer's address
// RULE5: pointers are 16 bits and wrap modulo 65536
// RULE6: pointer update never touches any status flag
// RULE7: indirect store writes accumulator at effective address, flags unchanged
// RULE8: bank literal loads 5-bit value into bank select register, flags unchanged
// RULE9: program latch literal loads 7-bit value into high latch, flags unchanged
// RULE10: accumulator literal loads 8-bit value in one cycle, flags unchanged
// RULE11: accumulator store copies accumulator to 7-bit file address in one cycle
// RULE12: indirect load sets zero when moved byte is zero, else clears it
`timescale 1ns/1ns
`default_nettype none
`include "mvd_regs.svh"
module mvd_core
  import mvd_pkg::*;
(
  input  wire logic        pclk,     // core clock
  input  wire logic        presetn,  // async reset, low active
  input  wire logic        ce,       // clock enable, freezes state when low
  input  wire logic        psel,     // apb select
  input  wire logic        penable,  // apb enable
  input  wire logic        pwrite,   // apb direction
  input  wire logic [11:0] paddr,    // apb byte address
  input  wire logic [31:0] pwdata,   // apb write data
  output logic      [31:0] prdata,   // apb read data
  output logic             pready,   // apb ready
  output logic             pslverr,  // apb error
  output logic      [7:0]  acc_out,  // accumulator
  output logic             zero_out  // zero flag
);
  ////////////////////////////////////////////////////////////////////////
  mvd_dec_t     dec;
  mvd_mem_req_t mreq;
  logic [13:0]  instr;
  logic [7:0]   acc_ff;
  logic [15:0]  ptr_ff [0:1];
  logic [4:0]   bank_ff;
  logic [6:0]   pcl_ff;
  logic         zero_ff;
  logic [15:0]  memaddr_ff;
  logic [15:0]  ea;
  logic [15:0]  nxt_ptr;
  logic [15:0]  raddr;
  logic [7:0]   rdata;
  logic [7:0]   file_rd;
  logic         wr_acc, rd_acc, exec;
  logic         map_ok;

  // write waits for pready high, read acts while pready is low, so a setup missed while frozen is answered, and acts, later
  assign wr_acc = psel && penable && pwrite && pready && ce;
  assign rd_acc = psel && !pwrite && !pready;
  assign exec   = wr_acc && (paddr == `MVD_INSTR_OFF);
  assign instr  = pwdata[13:0];

  mvd_decode u_dec (
    .instr (instr),
    .dec   (dec)
  );

  // wraps naturally on 16-bit adds
  function automatic logic [15:0] ptr_step(input logic [15:0] p, input logic dn);
    ptr_step = dn ? p - 16'h0001 : p + 16'h0001; // RULE5
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // effective address and pointer update
  always_comb begin
    ea      = ptr_ff[dec.ptr_sel];
    nxt_ptr = ptr_ff[dec.ptr_sel];
    if (dec.rel) begin
      ea = ptr_ff[dec.ptr_sel] + {{10{dec.offset[5]}}, dec.offset}; // RULE3
    end else begin
      unique case (dec.mode) // RULE2
        MVD_PRE_INC: begin
          nxt_ptr = ptr_step(ptr_ff[dec.ptr_sel], 1'b0);
          ea      = nxt_ptr;
        end
        MVD_PRE_DEC: begin
          nxt_ptr = ptr_step(ptr_ff[dec.ptr_sel], 1'b1);
          ea      = nxt_ptr;
        end
        MVD_POST_INC: nxt_ptr = ptr_step(ptr_ff[dec.ptr_sel], 1'b0);
        MVD_POST_DEC: nxt_ptr = ptr_step(ptr_ff[dec.ptr_sel], 1'b1);
      endcase
    end
  end

  // file-register read for apb inspection; window addresses follow the pointer
  always_comb begin
    raddr = memaddr_ff;
    if (memaddr_ff[15:7] == 9'h000 && memaddr_ff[6:0] == `MVD_INDF0_ADDR) begin
      raddr = ptr_ff[0]; // RULE4
    end else if (memaddr_ff[15:7] == 9'h000 && memaddr_ff[6:0] == `MVD_INDF1_ADDR) begin
      raddr = ptr_ff[1]; // RULE4
    end
  end

  // memory read port is shared: indirect load wins during execution
  assign file_rd = rdata;

  always_comb begin
    mreq = '0;
    if (exec && dec.op == MVD_OP_ISTORE) begin
      mreq.we    = 1'b1;
      mreq.addr  = ea; // RULE7
      mreq.wdata = acc_ff;
    end else if (exec && dec.op == MVD_OP_ACCSTORE) begin
      mreq.we    = 1'b1;
      mreq.wdata = acc_ff; // RULE11
      unique case (dec.faddr)
        `MVD_INDF0_ADDR: mreq.addr = ptr_ff[0]; // RULE4
        `MVD_INDF1_ADDR: mreq.addr = ptr_ff[1]; // RULE4
        default:         mreq.addr = {9'h000, dec.faddr};
      endcase
    end
  end

  logic [15:0] mem_raddr;
  assign mem_raddr = (exec && dec.op == MVD_OP_ILOAD) ? ea : raddr;

  mvd_dmem u_mem (
    .pclk  (pclk),
    .ce    (ce),
    .req   (mreq),
    .raddr (mem_raddr),
    .rdata (rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // accumulator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_ff <= `MVD_ACC_RST;
    end else if (ce && exec && dec.op == MVD_OP_ILOAD) begin
      acc_ff <= rdata; // RULE1
    end else if (ce && exec && dec.op == MVD_OP_LITACC) begin
      acc_ff <= dec.literal; // RULE10
    end else if (wr_acc && paddr == `MVD_ACC_OFF) begin
      acc_ff <= pwdata[7:0];
    end
  end

  // zero flag: only the indirect load and an apb status write touch it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_ff <= 1'b0;
    end else if (ce && exec && dec.op == MVD_OP_ILOAD) begin
      zero_ff <= (rdata == 8'h00); // RULE12 RULE1
    end else if (wr_acc && paddr == `MVD_STATUS_OFF) begin
      zero_ff <= pwdata[`MVD_ZERO_BIT];
    end
  end

  // pointers: relative form leaves them alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_ff[0] <= `MVD_PTR_RST;
      ptr_ff[1] <= `MVD_PTR_RST;
    end else if (ce && exec && !dec.rel &&
                 (dec.op == MVD_OP_ILOAD || dec.op == MVD_OP_ISTORE)) begin
      ptr_ff[dec.ptr_sel] <= nxt_ptr; // RULE2 RULE6
    end else if (wr_acc && paddr == `MVD_PTR0_OFF) begin
      ptr_ff[0] <= pwdata[15:0];
    end else if (wr_acc && paddr == `MVD_PTR1_OFF) begin
      ptr_ff[1] <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_ff <= `MVD_BANK_RST;
    end else if (ce && exec && dec.op == MVD_OP_BANK) begin
      bank_ff <= dec.literal[4:0]; // RULE8
    end else if (wr_acc && paddr == `MVD_BANK_OFF) begin
      bank_ff <= pwdata[4:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcl_ff <= `MVD_PCL_RST;
    end else if (ce && exec && dec.op == MVD_OP_PCL) begin
      pcl_ff <= dec.literal[6:0]; // RULE9
    end else if (wr_acc && paddr == `MVD_PCLATCH_OFF) begin
      pcl_ff <= pwdata[6:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      memaddr_ff <= 16'h0000;
    end else if (wr_acc && paddr == `MVD_MEMADDR_OFF) begin
      memaddr_ff <= pwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave: answer one cycle after setup; a stalled request is answered once ce returns
  always_comb begin
    map_ok = 1'b1;
    unique case (paddr)
      `MVD_CTRL_OFF, `MVD_INSTR_OFF, `MVD_ACC_OFF, `MVD_PTR0_OFF, `MVD_PTR1_OFF,
      `MVD_BANK_OFF, `MVD_PCLATCH_OFF, `MVD_STATUS_OFF, `MVD_MEMADDR_OFF,
      `MVD_MEMDATA_OFF: map_ok = 1'b1;
      default: map_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce && rd_acc) begin
      unique case (paddr)
        `MVD_ACC_OFF:     prdata <= {24'h00_0000, acc_ff};
        `MVD_PTR0_OFF:    prdata <= {16'h0000, ptr_ff[0]};
        `MVD_PTR1_OFF:    prdata <= {16'h0000, ptr_ff[1]};
        `MVD_BANK_OFF:    prdata <= {27'h000_0000, bank_ff};
        `MVD_PCLATCH_OFF: prdata <= {25'h000_0000, pcl_ff};
        `MVD_STATUS_OFF:  prdata <= {31'h0000_0000, zero_ff};
        `MVD_MEMADDR_OFF: prdata <= {16'h0000, memaddr_ff};
        `MVD_MEMDATA_OFF: prdata <= {24'h00_0000, file_rd};
        default:          prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= psel && !pready;
      pslverr <= psel && !pready && !map_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_out  <= `MVD_ACC_RST;
      zero_out <= 1'b0;
    end else if (ce) begin
      acc_out  <= acc_ff;
      zero_out <= zero_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic [7:0]  ld_exp;
  assign ld_exp = rdata;

  sequence ld_seq;
    exec && dec.op == MVD_OP_ILOAD && ce;
  endsequence

  iload_acc_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    ld_seq |=> acc_ff == $past(ld_exp)) else $error("indirect load acc mismatch");
  iload_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    ld_seq |=> zero_ff == ($past(ld_exp) == 8'h00)) else $error("zero flag wrong");
  rel_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
    (ce && exec && dec.rel) |=> ptr_ff[0] == $past(ptr_ff[0]) && ptr_ff[1] == $past(ptr_ff[1]))
    else $error("relative form moved pointer");
  preinc_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    (ld_seq and !dec.rel && dec.mode == MVD_PRE_INC && !dec.ptr_sel) |->
    ea == ptr_ff[0] + 16'h0001) else $error("pre-increment address wrong");
  wrap_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    (ce && exec && dec.op == MVD_OP_ISTORE && !dec.rel && dec.mode == MVD_POST_INC &&
     !dec.ptr_sel && ptr_ff[0] == 16'hFFFF) |=> ptr_ff[0] == 16'h0000)
    else $error("pointer did not wrap");
  store_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    (ce && exec && dec.op != MVD_OP_ILOAD && !(wr_acc && paddr == `MVD_STATUS_OFF))
    |=> $stable(zero_ff)) else $error("flag changed by non-load");
  bank_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    (ce && exec && dec.op == MVD_OP_BANK) |=> bank_ff == $past(instr[4:0]))
    else $error("bank literal not loaded");
  pcl_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    (ce && exec && dec.op == MVD_OP_PCL) |=> pcl_ff == $past(instr[6:0]))
    else $error("latch literal not loaded");
  litacc_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    (ce && exec && dec.op == MVD_OP_LITACC) |=> ##1 acc_out == $past(instr[7:0], 2))
    else $error("literal not in accumulator");
  accst_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    (exec && dec.op == MVD_OP_ACCSTORE && dec.faddr > 7'h01) |->
    mreq.we && mreq.addr == {9'h000, dec.faddr} && mreq.wdata == acc_ff)
    else $error("accumulator store wrong");
  window_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    (exec && dec.op == MVD_OP_ACCSTORE && dec.faddr == `MVD_INDF1_ADDR) |->
    mreq.addr == ptr_ff[1]) else $error("window not redirected");
  noflag_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    (ce && exec && dec.op == MVD_OP_ISTORE) |=> $stable(zero_ff))
    else $error("pointer update touched flag");
  // a low enable must hold the accumulator, zero flag and bank registers, the bus answer included
  freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ce |=> $stable(acc_ff) && $stable(zero_ff) && $stable(pready) && $stable(bank_ff))
    else $error("state moved while clock enable low");
  postdec_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    (ce && exec && dec.op == MVD_OP_ISTORE && !dec.rel && dec.mode == MVD_POST_DEC &&
     dec.ptr_sel) |-> mreq.addr == ptr_ff[1] && nxt_ptr == ptr_ff[1] - 16'h0001)
    else $error("post-decrement store wrong");
  window0_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    (exec && dec.op == MVD_OP_ACCSTORE && dec.faddr == `MVD_INDF0_ADDR) |->
    mreq.addr == ptr_ff[0]) else $error("window zero not redirected");
endmodule
`default_nettype wire

//--- pkg/mvd_regs.svh
// register offsets, field positions, reset values and memory size for the move datapath
// assumes inclusion by bare name from hdl/ and sim/ files
`ifndef MVD_REGS_SVH
`define MVD_REGS_SVH

// apb byte offsets
`define MVD_CTRL_OFF        12'h000
`define MVD_INSTR_OFF       12'h004
`define MVD_ACC_OFF         12'h008
`define MVD_PTR0_OFF        12'h00C
`define MVD_PTR1_OFF        12'h010
`define MVD_BANK_OFF        12'h014
`define MVD_PCLATCH_OFF     12'h018
`define MVD_STATUS_OFF      12'h01C
`define MVD_MEMADDR_OFF     12'h020
`define MVD_MEMDATA_OFF     12'h024

// instruction word fields (14 bits)
`define MVD_OP_MSB          13
`define MVD_OP_LSB          7
`define MVD_MODE_MSB        1
`define MVD_MODE_LSB        0
`define MVD_PSEL_BIT        2
`define MVD_OFF_MSB         5
`define MVD_OFF_LSB         0
`define MVD_RPSEL_BIT       6

// status bits and indirect window file addresses
`define MVD_ZERO_BIT        0
`define MVD_BUSY_BIT        1
`define MVD_INDF0_ADDR      7'h00
`define MVD_INDF1_ADDR      7'h01

// reset values
`define MVD_ACC_RST         8'h00
`define MVD_PTR_RST         16'h0000
`define MVD_BANK_RST        5'h00
`define MVD_PCL_RST         7'h00

`define MVD_MEM_WORDS       256
`endif

//--- pkg/mvd_pkg.sv
// types for the move-instruction datapath
// assumes mvd_regs.svh is on the include path
`default_nettype none
package mvd_pkg;
  typedef enum logic [2:0] {
    MVD_OP_NONE,
    MVD_OP_ILOAD,
    MVD_OP_ISTORE,
    MVD_OP_BANK,
    MVD_OP_PCL,
    MVD_OP_LITACC,
    MVD_OP_ACCSTORE
  } mvd_op_t;

  typedef enum logic [1:0] {
    MVD_PRE_INC  = 2'b00,
    MVD_PRE_DEC  = 2'b01,
    MVD_POST_INC = 2'b10,
    MVD_POST_DEC = 2'b11
  } mvd_mode_t;

  typedef struct packed {
    mvd_op_t     op;
    mvd_mode_t   mode;
    logic        ptr_sel;
    logic        rel;
    logic [5:0]  offset;
    logic [7:0]  literal;
    logic [6:0]  faddr;
  } mvd_dec_t;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mvd_mem_req_t;
endpackage
`default_nettype wire

//--- hdl/mvd_decode.sv
// instruction decoder for the move group
// assumes a 14-bit instruction word; unknown words decode to no operation
`timescale 1ns/1ns
`default_nettype none
`include "mvd_regs.svh"
module mvd_decode
  import mvd_pkg::*;
(
  input  wire logic [13:0] instr,   // instruction word
  output mvd_dec_t         dec      // decoded fields
);
  always_comb begin
    dec         = '0;
    dec.mode    = mvd_mode_t'(instr[`MVD_MODE_MSB:`MVD_MODE_LSB]);
    dec.ptr_sel = instr[`MVD_PSEL_BIT];
    dec.offset  = instr[`MVD_OFF_MSB:`MVD_OFF_LSB];
    dec.literal = instr[7:0];
    dec.faddr   = instr[6:0];
    if (instr[13:3] == 11'h002) begin
      dec.op = MVD_OP_ILOAD;
    end else if (instr[13:3] == 11'h003) begin
      dec.op = MVD_OP_ISTORE;
    end else if (instr[13:7] == 7'h7E) begin
      dec.op      = MVD_OP_ILOAD;
      dec.rel     = 1'b1;
      dec.ptr_sel = instr[`MVD_RPSEL_BIT];
    end else if (instr[13:7] == 7'h7F) begin
      dec.op      = MVD_OP_ISTORE;
      dec.rel     = 1'b1;
      dec.ptr_sel = instr[`MVD_RPSEL_BIT];
    end else if (instr[13:5] == 9'h001) begin
      dec.op = MVD_OP_BANK;
    end else if (instr[13:7] == 7'h63) begin
      dec.op = MVD_OP_PCL;
    end else if (instr[13:8] == 6'h30) begin
      dec.op = MVD_OP_LITACC;
    end else if (instr[13:7] == 7'h01) begin
      dec.op = MVD_OP_ACCSTORE;
    end
  end
endmodule
`default_nettype wire

//--- hdl/mvd_dmem.sv
// small data memory reached by the move datapath
// assumes synchronous write, combinational read; addresses wrap modulo depth
`timescale 1ns/1ns
`default_nettype none
`include "mvd_regs.svh"
module mvd_dmem
  import mvd_pkg::*;
(
  input  wire logic         pclk,    // clock
  input  wire logic         ce,      // clock enable
  input  wire mvd_mem_req_t req,     // write request
  input  wire logic [15:0]  raddr,   // read address
  output logic      [7:0]   rdata    // read data
);
  logic [7:0] mem_ff [0:`MVD_MEM_WORDS-1];
  always_ff @(posedge pclk) begin
    if (ce && req.we) begin
      mem_ff[req.addr[7:0]] <= req.wdata;
    end
  end
  assign rdata = mem_ff[raddr[7:0]];
endmodule
`default_nettype wire

//--- sim/test_move_instruction_datapath.sv
// self-checking bench for the move-instruction datapath, driven over apb
// assumes mvd_pkg is compiled first and mvd_regs.svh is on the include path
`timescale 1ns/1ns
`default_nettype none
`include "mvd_regs.svh"
module test_move_instruction_datapath
  import mvd_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  acc_out;
  logic        zero_out;
  logic        last_err;
  int          num_errors;
  int          checks_done;

  mvd_core mvd_core_inst (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .acc_out  (acc_out),
    .zero_out (zero_out)
  );

  initial pclk = 1'b0;
  always #4 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // entered just after a rising edge; leaves one idle edge so no signal is set twice at once
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      num_errors++;
      $display("ERROR %0t apb answer never came", $time);
      summarize();
    end
    rd       = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    apb(1'b1, a, d, rd);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string what);
    logic [31:0] rd;
    apb(1'b0, a, 32'h0000_0000, rd);
    check(rd, exp, what);
  endtask

  task automatic exec(input logic [13:0] ins);
    wr(`MVD_INSTR_OFF, {18'h0_0000, ins});
  endtask

  task automatic memchk(input logic [15:0] a, input logic [7:0] exp);
    wr(`MVD_MEMADDR_OFF, {16'h0000, a});
    rdchk(`MVD_MEMDATA_OFF, {24'h00_0000, exp}, "memory byte");
  endtask

  // instruction word builders
  function automatic logic [13:0] ind(input logic st, input logic n, input logic [1:0] mm);
    return {9'h000, 1'b1, st, n, mm};
  endfunction

  function automatic logic [13:0] rel(input logic st, input logic n, input logic [5:0] k);
    return {6'h3F, st, n, k};
  endfunction

  function automatic logic [13:0] litacc(input logic [7:0] k);
    return {6'h30, k};
  endfunction

  function automatic logic [13:0] accst(input logic [6:0] f);
    return {7'h01, f};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset_map();
    rdchk(`MVD_ACC_OFF, 32'h0000_0000, "acc reset");
    rdchk(`MVD_PTR0_OFF, 32'h0000_0000, "ptr0 reset");
    rdchk(`MVD_PTR1_OFF, 32'h0000_0000, "ptr1 reset");
    rdchk(`MVD_BANK_OFF, 32'h0000_0000, "bank reset");
    rdchk(`MVD_PCLATCH_OFF, 32'h0000_0000, "latch reset");
    rdchk(`MVD_STATUS_OFF, 32'h0000_0000, "status reset");
    rdchk(12'hFFC, 32'h0000_0000, "unmapped read");
    check({31'h0, last_err}, 32'h0000_0001, "unmapped error");
    $display("test reset_map done");
  endtask

  task automatic test_literals();
    wr(`MVD_STATUS_OFF, 32'h0000_0001);
    exec(litacc(8'h5A));
    @(negedge pclk);
    check({24'h00_0000, acc_out}, 32'h0000_005A, "acc literal one cycle");
    @(posedge pclk);
    exec({9'h001, 5'h1F});
    rdchk(`MVD_BANK_OFF, 32'h0000_001F, "bank literal");
    exec({7'h63, 7'h7F});
    rdchk(`MVD_PCLATCH_OFF, 32'h0000_007F, "latch literal");
    exec({9'h001, 5'h00});
    rdchk(`MVD_BANK_OFF, 32'h0000_0000, "bank literal zero");
    rdchk(`MVD_ACC_OFF, 32'h0000_005A, "acc after literals");
    rdchk(`MVD_STATUS_OFF, 32'h0000_0001, "flags kept by literals");
    $display("test literals done");
  endtask

  task automatic test_acc_store();
    exec(litacc(8'h96));
    exec(accst(7'h7F));
    memchk(16'h007F, 8'h96);
    wr(`MVD_PTR0_OFF, 32'h0000_0030);
    exec(litacc(8'h3D));
    exec(accst(`MVD_INDF0_ADDR));
    memchk(16'h0030, 8'h3D);
    memchk({9'h000, `MVD_INDF0_ADDR}, 8'h3D);
    rdchk(`MVD_STATUS_OFF, 32'h0000_0001, "flags kept by store");
    $display("test acc_store done");
  endtask

  task automatic test_store_modes();
    logic [15:0] ea;
    logic [15:0] ep;
    for (int i = 0; i < 4; i++) begin
      ea = (i == 0) ? 16'h0011 : (i == 1) ? 16'h000F : 16'h0010;
      ep = i[0] ? 16'h000F : 16'h0011;
      wr(`MVD_PTR1_OFF, 32'h0000_0010);
      exec(litacc(8'hC0 + 8'(i)));
      exec(ind(1'b1, 1'b1, i[1:0]));
      rdchk(`MVD_PTR1_OFF, {16'h0000, ep}, "ptr after store mode");
      memchk(ea, 8'hC0 + 8'(i));
      rdchk(`MVD_STATUS_OFF, 32'h0000_0001, "flags kept by store mode");
    end
    $display("test store_modes done");
  endtask

  task automatic test_wrap_load();
    wr(`MVD_PTR0_OFF, 32'h0000_FFFF);
    exec(litacc(8'hA5));
    exec(ind(1'b1, 1'b0, 2'b10));
    rdchk(`MVD_PTR0_OFF, 32'h0000_0000, "ptr wrap up");
    memchk(16'h00FF, 8'hA5);
    exec(litacc(8'h00));
    exec(ind(1'b0, 1'b0, 2'b01));
    rdchk(`MVD_PTR0_OFF, 32'h0000_FFFF, "ptr wrap down");
    rdchk(`MVD_ACC_OFF, 32'h0000_00A5, "indirect load data");
    rdchk(`MVD_STATUS_OFF, 32'h0000_0000, "zero clear on load");
    exec(litacc(8'h00));
    exec(accst(7'h50));
    exec(litacc(8'h77));
    wr(`MVD_PTR1_OFF, 32'h0000_0051);
    exec(ind(1'b0, 1'b1, 2'b01));
    rdchk(`MVD_ACC_OFF, 32'h0000_0000, "load of zero byte");
    rdchk(`MVD_STATUS_OFF, 32'h0000_0001, "zero set on load");
    check({31'h0, zero_out}, 32'h0000_0001, "zero output");
    exec(litacc(8'h11));
    wr(`MVD_PTR1_OFF, 32'h0000_004F);
    exec(ind(1'b0, 1'b1, 2'b00));
    rdchk(`MVD_PTR1_OFF, 32'h0000_0050, "pre-inc load ptr");
    rdchk(`MVD_STATUS_OFF, 32'h0000_0001, "zero after pre-inc");
    $display("test wrap_load done");
  endtask

  task automatic test_relative();
    wr(`MVD_PTR0_OFF, 32'h0000_0040);
    exec(litacc(8'h3C));
    exec(rel(1'b1, 1'b0, 6'h20));
    exec(litacc(8'h81));
    exec(rel(1'b1, 1'b0, 6'h1F));
    rdchk(`MVD_PTR0_OFF, 32'h0000_0040, "ptr kept by relative");
    memchk(16'h0020, 8'h3C);
    memchk(16'h005F, 8'h81);
    exec(rel(1'b0, 1'b0, 6'h20));
    rdchk(`MVD_ACC_OFF, 32'h0000_003C, "relative load low");
    rdchk(`MVD_STATUS_OFF, 32'h0000_0000, "zero after relative");
    wr(`MVD_PTR1_OFF, 32'h0000_0040);
    exec(rel(1'b0, 1'b1, 6'h1F));
    rdchk(`MVD_ACC_OFF, 32'h0000_0081, "relative load high");
    rdchk(`MVD_PTR1_OFF, 32'h0000_0040, "ptr1 kept by relative");
    $display("test relative done");
  endtask

  // request launched while frozen: it must stall, then run once the enable returns
  task automatic test_ce_freeze();
    int n;
    n = 0;
    ce      <= 1'b0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= 1'b1;
    paddr   <= `MVD_INSTR_OFF;
    pwdata  <= {18'h0_0000, litacc(8'hEE)};
    @(posedge pclk);
    penable <= 1'b1;
    repeat (3) @(posedge pclk);
    check({31'h0, pready}, 32'h0000_0000, "ready held while frozen");
    check({24'h00_0000, acc_out}, 32'h0000_0081, "acc frozen");
    ce <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    check({31'h0, pready}, 32'h0000_0001, "ready after thaw");
    if (pready !== 1'b1) begin
      summarize();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    rdchk(`MVD_ACC_OFF, 32'h0000_00EE, "instruction runs after thaw");
    $display("test ce_freeze done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    num_errors  = 0;
    checks_done = 0;
    last_err    = 1'b0;
    presetn     = 1'b0;
    ce          = 1'b1;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h000;
    pwdata      = 32'h0000_0000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    test_reset_map();
    test_literals();
    test_acc_store();
    test_store_modes();
    test_wrap_load();
    test_relative();
    test_ce_freeze();
    summarize();
  end
endmodule
`default_nettype wire
